// ---- design/tpm_group_select.sv ----
// Pixel group extractor: picks one group of a latched load and forms the palette address.
// Assumes the caller registers the outputs and steps the group index once per pixel.
`timescale 1ns/100ps
module tpm_group_select
(
    input wire logic [31:0] word,
    input wire tpm_pkg::tpm_mode_t mode,
    input wire logic [1:0] bpp_log,
    input wire logic [4:0] grp,
    input wire logic nibble_select_flag,
    input wire logic [7:0] page,
    input wire logic [7:0] mask,
    output logic [7:0] palette_index,
    output logic [7:0] red,
    output logic [7:0] green,
    output logic [7:0] blue,
    output logic overlay_active
);

    logic [15:0] nib_bus;
    logic [31:0] src;
    logic [31:0] shifted;
    logic [7:0] low_mask;
    logic [7:0] addr;
    logic [4:0] shamt;
    logic [8:0] span;

    // ----------------------------------------------------------------
    // Nibble bus, one nibble per byte, flag used unlatched
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_nib
            assign nib_bus[gi*4 +: 4] = nibble_select_flag ? word[gi*8+4 +: 4] : word[gi*8 +: 4];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Group extraction and page merge
    // ----------------------------------------------------------------
    always_comb
    begin
        src = (mode == tpm_pkg::TPM_MODE_NIB) ? {16'h0000, nib_bus} : word;
        shamt = 5'((grp << bpp_log));
        shifted = src >> shamt;
        span = 9'(9'h001 << (4'h1 << bpp_log));
        low_mask = 8'(span - 9'h001);
        red = 8'h00;
        green = 8'h00;
        blue = 8'h00;
        overlay_active = 1'b0;
        unique case (mode)
            tpm_pkg::TPM_MODE_TRUE:
            begin
                blue = word[31:24];
                green = word[23:16];
                red = word[15:8];
                addr = word[7:0];
                overlay_active = (word[7:0] != 8'h00) && (mask != 8'h00);
            end
            tpm_pkg::TPM_MODE_VGA, tpm_pkg::TPM_MODE_BPP8:
                addr = shifted[7:0];
            tpm_pkg::TPM_MODE_BPP1, tpm_pkg::TPM_MODE_BPP2, tpm_pkg::TPM_MODE_BPP4, tpm_pkg::TPM_MODE_NIB:
                addr = (page & ~low_mask) | (shifted[7:0] & low_mask);
            default:
                addr = 8'h00;
        endcase
        palette_index = addr & mask;
    end

endmodule

// ---- design/tpm_pixel_mux.sv ----
// Pixel port multiplexer with mode decode, load serialiser, reset paths and APB registers.
// Assumes APB master on pclk; pixel, sync and strobe inputs already synchronous to pclk.
`timescale 1ns/100ps
//
// Contract
// - Mode code 1Eh gives 8 bpp on 32 bits, four bytes, lowest first.
// - Mode bits 7 and 6 are ignored during decode.
// - Shift clock divide ratio equals pixels per bus load.
// - One shift edge captures all groups; shifted out lowest group first.
// - True colour: bits 31:24 blue, 23:16 green, 15:8 red.
// - True colour low byte is overlay; off when zero or mask cleared.
// - Nibble mode picks upper or lower nibble per byte, four pixels.
// - Writing mode low bits 2Dh performs a software reset of registers.
// - All select lines high plus store strobe rising edge resets registers.
// - After power-on reset the device is in pass-through mode.
// - Reset defaults 2Dh, 00h, 3Fh, 00h, 03h, FFh.
// - After reset the test register selects red.
// - Palette address ANDed with mask after page merge.
// - Pixel data latched on shift edge, or oscillator rise in pass-through.
// - Sync and blank sampled on control clock fall, or oscillator rise.
// - Internal delays align sync and blank with pixel data.
// - Device generates shift clock and separate video control clock.
// - General control bit 3 set, bit 2 clear forces nibble mode.
// - Nibble flag used directly, never latched.
// - One bpp: pixel is address bit 0, page gives upper seven.
module tpm_pixel_mux
(
    input wire logic pclk,
    input wire logic presetn,
    input wire tpm_pkg::tpm_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pixel_in,
    input wire logic [7:0] vga_in,
    input wire logic primary_osc_input,
    input wire logic [3:0] register_select_lines,
    input wire logic store_strobe,
    input wire logic nibble_select_flag,
    input wire logic hsync_n_in,
    input wire logic vsync_n_in,
    input wire logic blank_n_in,
    input wire logic passthrough_blank_in,
    output logic shift_clock,
    output logic video_ctrl_clock,
    output tpm_pkg::tpm_video_t video_out
);

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] icsel;
        logic [7:0] ocsel;
        logic [7:0] page;
        logic [7:0] gctl;
        logic [7:0] mask;
        logic [7:0] tsel;
        logic [31:0] word;
        tpm_pkg::tpm_mode_t lmode;
        logic [1:0] lbpp;
        logic [4:0] lglast;
        logic [4:0] grp;
        logic [4:0] div;
        logic sclk;
        logic [3:0] vdiv;
        logic vctl;
        logic osc_q;
        logic strobe_q;
        tpm_pkg::tpm_ctl_t ctl;
        logic [tpm_pkg::TPM_SYNC_DLY*3-1:0] pipe;
        tpm_pkg::tpm_video_t out;
        logic [31:0] rdata;
    } tpm_state_t;

    tpm_state_t s_reg;
    tpm_state_t s_next;
    tpm_pkg::tpm_mode_t cur_mode;
    logic [1:0] cur_bpp;
    logic [2:0] cur_glog;
    logic [2:0] ratio_log;
    logic [4:0] ratio_last;
    logic load;
    logic osc_rise;
    logic vctl_fall;
    logic hw_rst;
    logic sw_rst;
    logic wr_en;
    logic mapped;
    logic [7:0] sel_index;
    logic [7:0] sel_red;
    logic [7:0] sel_green;
    logic [7:0] sel_blue;
    logic sel_overlay;

    // ----------------------------------------------------------------
    // Group selector
    // ----------------------------------------------------------------
    tpm_group_select u_sel
    (
        .word(s_reg.word),
        .mode(s_reg.lmode),
        .bpp_log(s_reg.lbpp),
        .grp(s_reg.grp),
        .nibble_select_flag(nibble_select_flag),
        .page(s_reg.page),
        .mask(s_reg.mask),
        .palette_index(sel_index),
        .red(sel_red),
        .green(sel_green),
        .blue(sel_blue),
        .overlay_active(sel_overlay)
    );

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    always_comb
    begin
        cur_mode = tpm_pkg::TPM_MODE_VGA;
        cur_bpp = 2'h3;
        cur_glog = 3'h0;
        if (s_reg.gctl[tpm_pkg::TPM_GCTL_NIB_EN] && !s_reg.gctl[tpm_pkg::TPM_GCTL_SPLIT_EN])
        begin
            cur_mode = tpm_pkg::TPM_MODE_NIB;
            cur_bpp = 2'h2;
            cur_glog = 3'h2;
        end
        else if (s_reg.mode[5:0] == tpm_pkg::TPM_CODE_TRUE)
        begin
            cur_mode = tpm_pkg::TPM_MODE_TRUE;
        end
        else if (s_reg.mode[5:0] == tpm_pkg::TPM_CODE_NIB)
        begin
            cur_mode = tpm_pkg::TPM_MODE_NIB;
            cur_bpp = 2'h2;
            cur_glog = 3'h2;
        end
        else if (s_reg.mode[5:0] >= tpm_pkg::TPM_CODE_PAL_LO && s_reg.mode[5:0] <= tpm_pkg::TPM_CODE_PAL_HI)
        begin
            cur_bpp = s_reg.mode[3:2];
            unique case (s_reg.mode[3:2])
                2'h0: cur_mode = tpm_pkg::TPM_MODE_BPP1;
                2'h1: cur_mode = tpm_pkg::TPM_MODE_BPP2;
                2'h2: cur_mode = tpm_pkg::TPM_MODE_BPP4;
                2'h3: cur_mode = tpm_pkg::TPM_MODE_BPP8;
            endcase
            if (s_reg.mode[3:2] == 2'h3)
            begin
                cur_glog = 3'(3'h3 + {1'b0, s_reg.mode[1:0]} - 3'h3);
            end
            else
            begin
                cur_glog = 3'(3'h2 + {1'b0, s_reg.mode[1:0]} - {1'b0, s_reg.mode[3:2]});
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
        hw_rst = (register_select_lines == tpm_pkg::TPM_HWRST_SEL) && store_strobe && !s_reg.strobe_q;
        sw_rst = 1'b0;
        osc_rise = primary_osc_input && !s_reg.osc_q;
        s_next.osc_q = primary_osc_input;
        s_next.strobe_q = store_strobe;
        ratio_log = (s_reg.ocsel[2:0] > tpm_pkg::TPM_RATIO_LOG_MAX) ? 3'h0 : s_reg.ocsel[2:0];
        ratio_last = 5'((6'h01 << ratio_log) - 6'h01);
        if (cur_mode == tpm_pkg::TPM_MODE_VGA)
        begin
            load = osc_rise;
        end
        else
        begin
            load = (s_reg.div >= ratio_last);
        end
        s_next.div = load ? 5'h00 : 5'(s_reg.div + 5'h01);
        s_next.sclk = load;
        if (load)
        begin
            s_next.word = (cur_mode == tpm_pkg::TPM_MODE_VGA) ? {24'h000000, vga_in} : pixel_in;
            s_next.lmode = cur_mode;
            s_next.lbpp = cur_bpp;
            s_next.lglast = 5'((6'h01 << cur_glog) - 6'h01);
            s_next.grp = 5'h00;
        end
        else if (s_reg.grp != s_reg.lglast)
        begin
            s_next.grp = 5'(s_reg.grp + 5'h01);
        end
        s_next.vdiv = (s_reg.vdiv == tpm_pkg::TPM_VCTL_LAST) ? 4'h0 : 4'(s_reg.vdiv + 4'h1);
        s_next.vctl = (s_next.vdiv < tpm_pkg::TPM_VCTL_HALF);
        vctl_fall = s_reg.vctl && !s_next.vctl;
        if (cur_mode == tpm_pkg::TPM_MODE_VGA && osc_rise)
        begin
            s_next.ctl = '{hsync_n_in, vsync_n_in, passthrough_blank_in};
        end
        else if (cur_mode != tpm_pkg::TPM_MODE_VGA && vctl_fall)
        begin
            s_next.ctl = '{hsync_n_in, vsync_n_in, blank_n_in};
        end
        s_next.pipe = {s_reg.pipe[tpm_pkg::TPM_SYNC_DLY*3-4:0], s_reg.ctl};
        s_next.out.palette_index = sel_index;
        s_next.out.red = sel_red;
        s_next.out.green = sel_green;
        s_next.out.blue = sel_blue;
        s_next.out.overlay_active = sel_overlay;
        s_next.out.ctl = s_reg.pipe[tpm_pkg::TPM_SYNC_DLY*3-1 -: 3];
        mapped = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= tpm_pkg::TPM_ADDR_STATUS);
        if (apb_req.psel && !apb_req.penable)
        begin
            unique case (apb_req.paddr)
                tpm_pkg::TPM_ADDR_MODE: s_next.rdata = {24'h000000, s_reg.mode};
                tpm_pkg::TPM_ADDR_ICSEL: s_next.rdata = {24'h000000, s_reg.icsel};
                tpm_pkg::TPM_ADDR_OCSEL: s_next.rdata = {24'h000000, s_reg.ocsel};
                tpm_pkg::TPM_ADDR_PAGE: s_next.rdata = {24'h000000, s_reg.page};
                tpm_pkg::TPM_ADDR_GCTL: s_next.rdata = {24'h000000, s_reg.gctl};
                tpm_pkg::TPM_ADDR_MASK: s_next.rdata = {24'h000000, s_reg.mask};
                tpm_pkg::TPM_ADDR_TEST:
                begin
                    unique case (s_reg.tsel[1:0])
                        2'h0: s_next.rdata = {16'h0000, s_reg.tsel, s_reg.out.red};
                        2'h1: s_next.rdata = {16'h0000, s_reg.tsel, s_reg.out.green};
                        2'h2: s_next.rdata = {16'h0000, s_reg.tsel, s_reg.out.blue};
                        2'h3: s_next.rdata = {16'h0000, s_reg.tsel, 8'h00};
                    endcase
                end
                tpm_pkg::TPM_ADDR_STATUS:
                    s_next.rdata = {15'h0000, s_reg.lmode, s_reg.grp, s_reg.lglast};
                default: s_next.rdata = 32'h00000000;
            endcase
        end
        if (wr_en)
        begin
            unique case (apb_req.paddr)
                tpm_pkg::TPM_ADDR_MODE:
                begin
                    s_next.mode = apb_req.pwdata[7:0];
                    sw_rst = (apb_req.pwdata[5:0] == tpm_pkg::TPM_CODE_VGA);
                end
                tpm_pkg::TPM_ADDR_ICSEL: s_next.icsel = apb_req.pwdata[7:0];
                tpm_pkg::TPM_ADDR_OCSEL: s_next.ocsel = apb_req.pwdata[7:0];
                tpm_pkg::TPM_ADDR_PAGE: s_next.page = apb_req.pwdata[7:0];
                tpm_pkg::TPM_ADDR_GCTL: s_next.gctl = apb_req.pwdata[7:0];
                tpm_pkg::TPM_ADDR_MASK: s_next.mask = apb_req.pwdata[7:0];
                tpm_pkg::TPM_ADDR_TEST: s_next.tsel = apb_req.pwdata[7:0];
                default: s_next.mode = s_next.mode;
            endcase
        end
        if (hw_rst || sw_rst)
        begin
            s_next.mode = tpm_pkg::TPM_RST_MODE;
            s_next.icsel = tpm_pkg::TPM_RST_ICSEL;
            s_next.ocsel = tpm_pkg::TPM_RST_OCSEL;
            s_next.page = tpm_pkg::TPM_RST_PAGE;
            s_next.gctl = tpm_pkg::TPM_RST_GCTL;
            s_next.mask = tpm_pkg::TPM_RST_MASK;
            s_next.tsel = tpm_pkg::TPM_RST_TEST;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
            s_reg.mode <= tpm_pkg::TPM_RST_MODE;
            s_reg.icsel <= tpm_pkg::TPM_RST_ICSEL;
            s_reg.ocsel <= tpm_pkg::TPM_RST_OCSEL;
            s_reg.page <= tpm_pkg::TPM_RST_PAGE;
            s_reg.gctl <= tpm_pkg::TPM_RST_GCTL;
            s_reg.mask <= tpm_pkg::TPM_RST_MASK;
            s_reg.tsel <= tpm_pkg::TPM_RST_TEST;
            s_reg.lmode <= tpm_pkg::TPM_MODE_VGA;
            s_reg.lbpp <= 2'h3;
            s_reg.ctl <= 3'h7;
            s_reg.pipe <= '1;
            s_reg.out.ctl <= 3'h7;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = s_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = apb_req.psel && apb_req.penable && !mapped;
    assign shift_clock = s_reg.sclk;
    assign video_ctrl_clock = s_reg.vctl;
    assign video_out = s_reg.out;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_SW_RESET: assert property (wr_en && apb_req.paddr == tpm_pkg::TPM_ADDR_MODE && apb_req.pwdata[5:0] == 6'h2d
        |=> s_reg.mask == 8'hff && s_reg.ocsel == 8'h3f && s_reg.gctl == 8'h03)
        else $error("software reset did not restore defaults");
    AST_HW_RESET: assert property (register_select_lines == 4'hf && $rose(store_strobe)
        |=> s_reg.mode == 8'h2d && s_reg.page == 8'h00 && s_reg.tsel == 8'h00)
        else $error("hardware reset did not restore defaults");
    AST_MODE_TOP_BITS: assert property (s_reg.mode == 8'hd3 && !s_reg.gctl[3]
        |-> cur_mode == tpm_pkg::TPM_MODE_BPP1 && cur_glog == 3'h5)
        else $error("upper mode bits changed the decode");
    AST_BYTE_ORDER: assert property (load && cur_mode == tpm_pkg::TPM_MODE_BPP8 && cur_glog == 3'h2
        |=> s_reg.grp == 5'h00 ##1 s_reg.grp == 5'h01 ##1 s_reg.grp == 5'h02 ##1 s_reg.grp == 5'h03)
        else $error("byte groups not shifted lowest first");
    AST_RATIO: assert property (load && cur_mode != tpm_pkg::TPM_MODE_VGA && s_reg.ocsel == 8'h12
        ##1 (s_reg.ocsel == 8'h12 && cur_mode != tpm_pkg::TPM_MODE_VGA) [*4]
        |-> load && !$past(load) && !$past(load, 2) && !$past(load, 3))
        else $error("shift clock period does not match ratio");
    AST_TRUE_ROUTE: assert property (s_reg.lmode == tpm_pkg::TPM_MODE_TRUE
        |=> video_out.blue == $past(s_reg.word[31:24]) && video_out.red == $past(s_reg.word[15:8]))
        else $error("true colour bytes misrouted");
    AST_OVERLAY_OFF: assert property (s_reg.lmode == tpm_pkg::TPM_MODE_TRUE && (s_reg.word[7:0] == 8'h00
        || s_reg.mask == 8'h00) |=> !video_out.overlay_active)
        else $error("overlay shown while suppressed");
    AST_MASK_ZERO: assert property (s_reg.mask == 8'h00 |=> video_out.palette_index == 8'h00)
        else $error("zero mask did not force location zero");
    AST_NIB_OVERRIDE: assert property (s_reg.gctl[3:2] == 2'h2 |-> cur_mode == tpm_pkg::TPM_MODE_NIB)
        else $error("nibble enable did not override mode");
    AST_MODE_HOLD: assert property (!load |=> $stable(s_reg.lmode) && $stable(s_reg.word))
        else $error("mode changed inside a bus load");
    AST_SYNC_ALIGN: assert property (1'b1 |-> ##3 video_out.ctl == $past(s_reg.ctl, 3))
        else $error("sync pipeline length wrong");

    COV_BPP8_LOAD: cover property (load && cur_mode == tpm_pkg::TPM_MODE_BPP8);
    COV_TRUE_OVERLAY: cover property (video_out.overlay_active);
    COV_NIB_LOAD: cover property (load && cur_mode == tpm_pkg::TPM_MODE_NIB);
    COV_HW_RESET: cover property (hw_rst);

endmodule

// ---- design/tpm_pkg.sv ----
// Package for the pixel port multiplexer: register map, reset values, mode codes, carriers.
// Assumes one 25 MHz clock that also serves as the pixel dot clock.
package tpm_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] TPM_ADDR_MODE = 8'h00;
    localparam logic [7:0] TPM_ADDR_ICSEL = 8'h04;
    localparam logic [7:0] TPM_ADDR_OCSEL = 8'h08;
    localparam logic [7:0] TPM_ADDR_PAGE = 8'h0c;
    localparam logic [7:0] TPM_ADDR_GCTL = 8'h10;
    localparam logic [7:0] TPM_ADDR_MASK = 8'h14;
    localparam logic [7:0] TPM_ADDR_TEST = 8'h18;
    localparam logic [7:0] TPM_ADDR_STATUS = 8'h1c;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TPM_RST_MODE = 8'h2d;
    localparam logic [7:0] TPM_RST_ICSEL = 8'h00;
    localparam logic [7:0] TPM_RST_OCSEL = 8'h3f;
    localparam logic [7:0] TPM_RST_PAGE = 8'h00;
    localparam logic [7:0] TPM_RST_GCTL = 8'h03;
    localparam logic [7:0] TPM_RST_MASK = 8'hff;
    localparam logic [7:0] TPM_RST_TEST = 8'h00;

    // ----------------------------------------------------------------
    // Mode codes, field positions, timing counts
    // ----------------------------------------------------------------
    localparam logic [5:0] TPM_CODE_VGA = 6'h2d;
    localparam logic [5:0] TPM_CODE_TRUE = 6'h0d;
    localparam logic [5:0] TPM_CODE_NIB = 6'h1f;
    localparam logic [5:0] TPM_CODE_PAL_LO = 6'h10;
    localparam logic [5:0] TPM_CODE_PAL_HI = 6'h1e;
    localparam int TPM_GCTL_NIB_EN = 3;
    localparam int TPM_GCTL_SPLIT_EN = 2;
    localparam logic [3:0] TPM_HWRST_SEL = 4'hf;
    localparam logic [2:0] TPM_RATIO_LOG_MAX = 3'h5;
    localparam logic [3:0] TPM_VCTL_LAST = 4'h3;
    localparam logic [3:0] TPM_VCTL_HALF = 4'h2;
    localparam int TPM_SYNC_DLY = 2;

    typedef enum logic [6:0] {
        TPM_MODE_VGA = 7'h01,
        TPM_MODE_BPP1 = 7'h02,
        TPM_MODE_BPP2 = 7'h04,
        TPM_MODE_BPP4 = 7'h08,
        TPM_MODE_BPP8 = 7'h10,
        TPM_MODE_TRUE = 7'h20,
        TPM_MODE_NIB = 7'h40
    } tpm_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tpm_apb_req_t;

    typedef struct packed {
        logic hsync_n;
        logic vsync_n;
        logic blank_n;
    } tpm_ctl_t;

    typedef struct packed {
        logic [7:0] palette_index;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic overlay_active;
        tpm_ctl_t ctl;
    } tpm_video_t;

endpackage

// ---- testbench/tpm_pixel_mux_test.sv ----
// Testbench for the pixel port multiplexer: APB register tasks and pixel load checks.
// Assumes the frame buffer model on the pixel bus and a 25 MHz pclk.
`timescale 1ns/100ps
module tpm_pixel_mux_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    tpm_pkg::tpm_apb_req_t req = '0;
    logic [31:0] prdata, pixel_in, held, rd;
    logic pready, pslverr, err, shift_clock, video_ctrl_clock;
    logic osc = 1'b0, strobe = 1'b0, flag = 1'b0, hs_n = 1'b1, bl_n = 1'b1, pb_n = 1'b1;
    logic [3:0] rsl = 4'h0;
    logic [3:0] cnt;
    tpm_pkg::tpm_video_t vo;
    int error_cnt = 0, check_count = 0, i;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [7:0] rv [7] = '{8'h2d, 8'h00, 8'h3f, 8'h00, 8'h03, 8'hff, 8'h00};
    always #20 pclk = ~pclk;
    always @(posedge pclk) osc <= ~osc;
    always @(posedge pclk) held <= pixel_in;
    tpm_pixel_mux dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixel_in(pixel_in), .vga_in(8'h5a), .primary_osc_input(osc),
        .register_select_lines(rsl), .store_strobe(strobe), .nibble_select_flag(flag), .hsync_n_in(hs_n),
        .vsync_n_in(1'b1), .blank_n_in(bl_n), .passthrough_blank_in(pb_n), .shift_clock(shift_clock),
        .video_ctrl_clock(video_ctrl_clock), .video_out(vo));
    tpm_vram_model vram (.pclk(pclk), .presetn(presetn), .shift_clock(shift_clock), .pixel_in(pixel_in));
    // --------------------------------
    // Tasks
    // --------------------------------
    task summarize;
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    task wait_load;
        int n;
        for (n = 0; n < 100 && shift_clock !== 1'b1; n++) @(negedge pclk);
    endtask
    task next_load;
        @(negedge pclk);
        wait_load();
        @(negedge pclk);
        wait_load();
    endtask
    task pal(input int bpp, input int ng, input logic nib, input logic [7:0] page);
        logic [31:0] w;
        logic [7:0] m;
        int g, off;
        next_load();
        w = held;
        m = 8'((1 << bpp) - 1);
        for (g = 0; g < ng; g++)
        begin
            @(negedge pclk);
            off = nib ? 8 * g + 4 * flag : g * bpp;
            chk(32'(vo.palette_index), 32'((page & ~m) | (8'(w >> off) & m)));
        end
    endtask
    task tc(input logic [7:0] mask);
        logic [31:0] w;
        next_load();
        w = held;
        @(negedge pclk);
        chk(32'(vo.blue), 32'(w[31:24]));
        chk(32'(vo.green), 32'(w[23:16]));
        chk(32'(vo.red), 32'(w[15:8]));
        chk(32'(vo.palette_index), 32'(w[7:0] & mask));
        chk(32'(vo.overlay_active), 32'(w[7:0] != 8'h00 && mask != 8'h00));
    endtask
    // --------------------------------
    // Sequence
    // --------------------------------
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 7; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, 32'(rv[i]));
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        repeat (8) @(negedge pclk);
        chk(32'(vo.palette_index), 32'h5a);
        apb(1'b1, 8'h08, 32'h12);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h00, 32'h1e);
        pal(8, 4, 1'b0, 8'h00);
        apb(1'b1, 8'h00, 32'hd3);
        apb(1'b1, 8'h08, 32'h15);
        apb(1'b1, 8'h0c, 32'ha4);
        pal(1, 32, 1'b0, 8'ha4);
        apb(1'b1, 8'h10, 32'h08);
        apb(1'b1, 8'h08, 32'h12);
        apb(1'b1, 8'h0c, 32'h30);
        flag <= 1'b1;
        pal(4, 4, 1'b1, 8'h30);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h00, 32'h0d);
        apb(1'b1, 8'h08, 32'h0);
        tc(8'hff);
        apb(1'b1, 8'h14, 32'h0);
        tc(8'h00);
        @(posedge pclk) hs_n <= 1'b0;
        bl_n <= 1'b0;
        repeat (12) @(negedge pclk);
        chk(32'(vo.ctl), 32'h2);
        cnt = 4'h0;
        repeat (8) @(negedge pclk) cnt = cnt + 4'(video_ctrl_clock);
        chk(32'(cnt), 32'h4);
        apb(1'b1, 8'h00, 32'h6d);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h3f);
        hs_n <= 1'b1;
        bl_n <= 1'b1;
        pb_n <= 1'b0;
        repeat (8) @(negedge pclk);
        chk(32'(vo.ctl), 32'h6);
        apb(1'b1, 8'h14, 32'h0f);
        rsl <= 4'hf;
        repeat (2)
        begin
            @(posedge pclk) strobe <= 1'b1;
            @(posedge pclk) strobe <= 1'b0;
        end
        @(posedge pclk) rsl <= 4'h0;
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'hff);
        summarize();
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        summarize();
    end
endmodule

// ---- testbench/tpm_vram_model.sv ----
// Frame buffer model: serial port that steps to the next word on each shift pulse.
// Assumes shift_clock is a one-cycle pulse synchronous to pclk.
`timescale 1ns/100ps
module tpm_vram_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic shift_clock,
    output logic [31:0] pixel_in
);
    logic [7:0] ptr_reg;
    // --------------------------------
    // Serial pointer
    // --------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ptr_reg <= 8'h00;
        else if (shift_clock)
            ptr_reg <= ptr_reg + 8'h01;
    end
    assign pixel_in = {ptr_reg ^ 8'ha5, ptr_reg + 8'h5c, ptr_reg ^ 8'h36, ptr_reg + 8'h01};
endmodule
